// [bench/dmg_periph_model.sv]
`timescale 1ns/1ns
`include "dmg_params.svh"

module dmg_periph_model
(
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  // bench controls
  input  wire logic [`DMG_NCH-1:0] fire_i,
  input  wire logic                slow_i,
  // block outputs seen by peripherals and interrupt controller
  input  wire logic [`DMG_NCH-1:0] grant_i,
  input  wire logic [`DMG_NCH-1:0] pass_i,
  // towards the block
  output logic      [`DMG_NCH-1:0] req_o,
  output logic      [`DMG_NCH-1:0] done_o,
  // interrupt controller and datapath tallies
  output int                       pass_cnt_o [`DMG_NCH],
  output int                       grant_cnt_o [`DMG_NCH]
);
  int cd [`DMG_NCH];

  // peripheral requests are single-cycle pulses, one per channel per cycle
  assign req_o = fire_i;

  // a granted unit ends after one cycle, or six for a slow peripheral
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    for (int c = 0; c < `DMG_NCH; c++)
    begin
      if (!rst_n_i)
      begin
        cd[c]          <= 0;
        done_o[c]      <= 1'b0;
        pass_cnt_o[c]  <= 0;
        grant_cnt_o[c] <= 0;
      end
      else
      begin
        done_o[c]      <= (cd[c] == 1);
        cd[c]          <= grant_i[c] ? (slow_i ? 6 : 1) : (cd[c] != 0 ? cd[c] - 1 : 0);
        pass_cnt_o[c]  <= pass_cnt_o[c] + int'(pass_i[c]);
        grant_cnt_o[c] <= grant_cnt_o[c] + int'(grant_i[c]);
      end
    end
  end
endmodule : dmg_periph_model

// [bench/tb.sv]
`timescale 1ns/1ns
`include "dmg_params.svh"

module tb
  import dmg_pkg::*;
;
  localparam int NO = 0;
  localparam int PS = 1;
  localparam int XF = 2;
  logic                core_clk;
  logic                rst_n;
  logic                nmi;
  logic                slow;
  logic [`DMG_NCH-1:0] fire;
  logic [`DMG_NCH-1:0] req;
  logic [`DMG_NCH-1:0] done;
  logic [`DMG_NCH-1:0] reload;
  logic [`DMG_NCH-1:0] grant;
  logic [`DMG_NCH-1:0] pass;
  logic [`DMG_NCH-1:0] end_irq;
  logic                irq;
  dmg_apb_req_t        apb;
  dmg_apb_rsp_t        apb_rsp;
  int                  pass_cnt [`DMG_NCH];
  int                  grant_cnt [`DMG_NCH];
  int                  n_mismatch;
  int                  tests_run;
  logic [31:0]         rd;
  logic                err;

  dmg_top u_dmg_top (.core_clk_i(core_clk), .rst_n_i(rst_n), .apb_i(apb), .apb_o(apb_rsp), .nmi_i(nmi),
    .periph_req_i(req), .xfer_done_i(done), .reload_i(reload), .grant_o(grant), .pass_o(pass),
    .end_irq_o(end_irq), .irq_o(irq));

  dmg_periph_model u_dmg_periph_model (.core_clk_i(core_clk), .rst_n_i(rst_n), .fire_i(fire), .slow_i(slow),
    .grant_i(grant), .pass_i(pass), .req_o(req), .done_o(done), .pass_cnt_o(pass_cnt), .grant_cnt_o(grant_cnt));

  // free-running 20 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // one apb transfer; request held until pready is sampled high
  task automatic apb_rw(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    apb.psel    <= 1'b1;
    apb.penable <= 1'b0;
    apb.paddr   <= a;
    apb.pwrite  <= wr;
    apb.pwdata  <= wd;
    @(posedge core_clk);
    apb.penable <= 1'b1;
    // no local limit: a slave that never answers is caught by the watchdog
    do
    begin
      @(posedge core_clk);
    end
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
  endtask : apb_rw

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb_rw(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb_rw(1'b0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask : rdchk

  // one request on a channel; expect nothing, a pass-through or a grant
  task automatic poke(input int ch, input int exp);
    int p;
    int g;
    p = pass_cnt[ch];
    g = grant_cnt[ch];
    @(posedge core_clk);
    fire <= 10'h001 << ch;
    @(posedge core_clk);
    fire <= '0;
    tick(10);
    chk(32'(pass_cnt[ch] - p), 32'(exp == PS), "pass count");
    chk(32'(grant_cnt[ch] - g), 32'(exp == XF), "grant count");
  endtask : poke

  task automatic row(input int ch, input logic n, input logic g, input logic en, input int cnt, input int exp);
    @(posedge core_clk);
    nmi <= n;
    wr(`DMG_OFF_CTRL, {31'h0, g});
    wr(`DMG_OFF_CHEN, en ? 32'h1 << ch : 32'h0);
    wr(`DMG_OFF_COUNT + 12'(4 * ch), 32'(cnt));
    poke(ch, exp);
  endtask : row

  // cut a hang short well beyond the expected few hundred cycles
  initial
  begin
    #1000000;
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    int n;
    apb = '0;
    nmi = 1'b0;
    slow = 1'b0;
    fire = '0;
    reload = '0;
    n_mismatch = 0;
    tests_run = 0;
    rst_n = 1'b0;
    tick(2);
    rst_n <= 1'b1;
    rdchk(`DMG_OFF_CTRL, 32'h0);
    rdchk(`DMG_OFF_CHEN, 32'h0);
    rdchk(`DMG_OFF_IEN, 32'h0);
    rdchk(`DMG_OFF_COUNT + 12'h024, 32'h0);
    apb_rw(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
    row(0, 0, 0, 0, 3, PS);
    row(0, 0, 1, 0, 0, PS);
    row(0, 0, 1, 0, 3, XF);
    row(2, 1, 1, 1, 0, NO);
    row(2, 0, 0, 1, 0, PS);
    row(2, 0, 1, 0, 0, PS);
    row(2, 0, 1, 1, 0, XF);
    row(2, 0, 1, 1, 0, XF);
    row(4, 1, 1, 1, 5, NO);
    row(4, 0, 0, 1, 5, PS);
    row(4, 0, 1, 1, 0, PS);
    row(6, 1, 1, 1, 0, NO);
    row(6, 0, 0, 1, 0, NO);
    row(6, 0, 1, 0, 0, NO);
    row(6, 0, 1, 1, 0, XF);
    row(8, 1, 1, 1, 2, NO);
    row(8, 0, 1, 0, 2, NO);
    row(8, 0, 1, 1, 2, XF);
    $display("test decision table done");
    for (int i = 0; i < `DMG_NCH; i++)
    begin
      if (i == 4 || i == 8)
      begin
        wr(`DMG_OFF_IEN, 32'h1 << i);
        wr(`DMG_OFF_CHEN, 32'h1 << i);
        wr(`DMG_OFF_COUNT + 12'(4 * i), 32'h1);
        poke(i, XF);
        rdchk(`DMG_OFF_TEF, 32'h1 << i);
        chk(32'(end_irq), 32'h1 << i, "end interrupt");
        poke(i, NO);
        wr(`DMG_OFF_COUNT + 12'(4 * i), 32'h3);
        poke(i, NO);
        wr(`DMG_OFF_IEN, 32'h0);
        tick(2);
        chk(32'(end_irq), 32'h0, "end interrupt gated");
        wr(`DMG_OFF_TEF, ~(32'h1 << i));
        rdchk(`DMG_OFF_TEF, 32'h0);
        poke(i, XF);
      end
    end
    $display("test end flag done");
    rdchk(`DMG_OFF_ISTAT, 32'h7);
    wr(`DMG_OFF_IMASK, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1, "block interrupt");
    wr(`DMG_OFF_ISTAT, 32'h7);
    tick(2);
    chk({31'h0, irq}, 32'h0, "block interrupt cleared");
    rdchk(`DMG_OFF_ISTAT, 32'h0);
    rdchk(`DMG_OFF_CVF, 32'h44);
    wr(`DMG_OFF_CVF, 32'hffff_fffb);
    rdchk(`DMG_OFF_CVF, 32'h40);
    wr(`DMG_OFF_CHEN, 32'h4);
    wr(`DMG_OFF_IEN, 32'h4);
    poke(2, XF);
    chk(32'(end_irq), 32'h4, "completion interrupt");
    wr(`DMG_OFF_CVF, 32'hffff_fffb);
    rdchk(`DMG_OFF_CVF, 32'h40);
    chk(32'(end_irq), 32'h0, "completion interrupt cleared");
    @(posedge core_clk);
    reload <= 10'h008;
    @(posedge core_clk);
    reload <= '0;
    rdchk(`DMG_OFF_RPF, 32'h8);
    wr(`DMG_OFF_RPF, 32'h0);
    rdchk(`DMG_OFF_RPF, 32'h8);
    wr(`DMG_OFF_RPF, 32'h8);
    rdchk(`DMG_OFF_RPF, 32'h0);
    $display("test flag clearing done");
    wr(`DMG_OFF_COUNT, 32'h5);
    wr(`DMG_OFF_COUNT + 12'h004, 32'h5);
    slow <= 1'b1;
    @(posedge core_clk);
    fire <= 10'h003;
    @(posedge core_clk);
    fire <= '0;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do
      begin
        @(posedge core_clk);
        n++;
      end
      while (grant === '0 && n < 20);
      chk(32'(grant), 32'h1 << k, "grant order");
    end
    $display("test priority done");
    tick(10);
    report_and_stop();
  end
endmodule : tb

// [core/dmg_gate.sv]
`timescale 1ns/1ns

module dmg_gate
  import dmg_pkg::*;
(
  // channel configuration
  input  wire dmg_grp_t grp_i,
  // live control bits
  input  wire logic     nmi_i,
  input  wire logic     global_dma_enable_i,
  input  wire logic     channel_enable_i,
  input  wire logic     count_zero_i,
  input  wire logic     completion_valid_flag_i,
  input  wire logic     transfer_end_flag_i,
  // decision
  output dmg_dec_t      dec_o
);

  // pure combinational table, so any control change counts on the next request
  always_comb
  begin
    dec_o = DEC_OFF;
    case (grp_i)
      GRP_TG_ADC:
        dec_o = nmi_i ? DEC_MASK : (!global_dma_enable_i || count_zero_i) ? DEC_PASS : DEC_XFER;
      GRP_TIMER:
        dec_o = nmi_i ? DEC_MASK : (global_dma_enable_i && channel_enable_i) ? DEC_XFER : DEC_PASS;
      GRP_SERIAL:
        if (nmi_i)
          dec_o = DEC_MASK;
        else if (!global_dma_enable_i)
          dec_o = DEC_PASS;
        else if (transfer_end_flag_i)
          dec_o = DEC_MASK;
        else
          dec_o = count_zero_i ? DEC_PASS : DEC_XFER;
      GRP_CAN_RX:
        dec_o = (!nmi_i && global_dma_enable_i && channel_enable_i) ? DEC_XFER : DEC_OFF;
      GRP_CAN_TX:
        dec_o = (!nmi_i && global_dma_enable_i && channel_enable_i && !transfer_end_flag_i) ? DEC_XFER : DEC_OFF;
      default:
        dec_o = DEC_OFF;
    endcase
  end

  // completion flag is unused by every group table
  wire unused_cvf = completion_valid_flag_i;

endmodule : dmg_gate

// [core/dmg_params.svh]
`ifndef DMG_PARAMS_SVH
`define DMG_PARAMS_SVH

// channel layout: two channels per group, channel 0 has top priority
`define DMG_NCH        10
`define DMG_CW         16
`define DMG_PER_GRP    2

// register byte offsets
`define DMG_OFF_CTRL   12'h000
`define DMG_OFF_CHEN   12'h004
`define DMG_OFF_IEN    12'h008
`define DMG_OFF_CVF    12'h00c
`define DMG_OFF_TEF    12'h010
`define DMG_OFF_RPF    12'h014
`define DMG_OFF_ISTAT  12'h018
`define DMG_OFF_IMASK  12'h01c
`define DMG_OFF_STATE  12'h020
`define DMG_OFF_COUNT  12'h040

// block interrupt status fields
`define DMG_IST_DROP   0
`define DMG_IST_END    1
`define DMG_IST_NMI    2
`define DMG_IST_W      3

// reset values
`define DMG_RST_CTRL   1'h0
`define DMG_RST_CHAN   10'h000
`define DMG_RST_IMASK  3'h0

`endif

// [core/dmg_pkg.sv]
`include "dmg_params.svh"

package dmg_pkg;

  // channel groups
  typedef enum logic [2:0] {
    GRP_TG_ADC = 3'b000,
    GRP_TIMER  = 3'b001,
    GRP_SERIAL = 3'b010,
    GRP_CAN_RX = 3'b011,
    GRP_CAN_TX = 3'b100
  } dmg_grp_t;

  // per-channel request handling decision
  typedef enum logic [1:0] {
    DEC_PASS = 2'b00,
    DEC_MASK = 2'b01,
    DEC_XFER = 2'b10,
    DEC_OFF  = 2'b11
  } dmg_dec_t;

  // apb request from the master
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } dmg_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dmg_apb_rsp_t;

  // whole state of the gating block
  typedef struct packed {
    logic                               global_dma_enable;
    logic [`DMG_NCH-1:0]                channel_enable;
    logic [`DMG_NCH-1:0]                channel_interrupt_enable;
    logic [`DMG_NCH-1:0]                completion_valid_flag;
    logic [`DMG_NCH-1:0]                transfer_end_flag;
    logic [`DMG_NCH-1:0]                reload_pointer_flag;
    logic [`DMG_NCH-1:0][`DMG_CW-1:0]   transfer_count;
    logic [`DMG_NCH-1:0]                pend;
    logic [`DMG_NCH-1:0]                grant;
    logic [`DMG_NCH-1:0]                pass;
    logic [`DMG_NCH-1:0]                end_irq;
    logic [`DMG_IST_W-1:0]              ist;
    logic [`DMG_IST_W-1:0]              imask;
    logic                               irq;
    dmg_apb_rsp_t                       rsp;
  } dmg_state_t;

  // group served by a channel index
  function automatic dmg_grp_t dmg_chan_group(input int unsigned ch);
    case (ch / `DMG_PER_GRP)
      0:       return GRP_TG_ADC;
      1:       return GRP_TIMER;
      2:       return GRP_SERIAL;
      3:       return GRP_CAN_RX;
      default: return GRP_CAN_TX;
    endcase
  endfunction : dmg_chan_group

endpackage : dmg_pkg

// [core/dmg_top.sv]
// What this block does
// - Timer-G/converter channels, with no NMI and DMA on, pass requests at zero count and transfer otherwise.
// - Capture/compare timer channels mask on NMI, pass if either enable is off, else transfer ignoring completion.
// - Serial and UART channels mask on NMI and pass while the global enable is off.
// - Serial and UART channels with DMA on mask on end flag, else pass at zero count and transfer at nonzero count.
// - CAN receive channels transfer only with no NMI and both enables set, else stay off.
// - CAN transmit channels transfer only with no NMI, both enables set and the end flag clear.
// - Writing zero to a completion or end flag bit clears it, even if it set after the last read.
// - Writing one to a reload pointer flag bit clears it whether or not it was seen set.
// - Masked requests vanish, passed requests reach the interrupt controller unaffected by the interrupt enable.
// - A channel end interrupt follows its completion or end flag and is gated by its interrupt enable.
// - Simultaneous requests are granted lowest channel number first.
`timescale 1ns/1ns

module dmg_top
  import dmg_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  // apb slave
  input  wire dmg_apb_req_t        apb_i,
  output dmg_apb_rsp_t             apb_o,
  // peripheral side
  input  wire logic                nmi_i,
  input  wire logic [`DMG_NCH-1:0] periph_req_i,
  input  wire logic [`DMG_NCH-1:0] xfer_done_i,
  input  wire logic [`DMG_NCH-1:0] reload_i,
  // datapath and interrupt controller side
  output logic      [`DMG_NCH-1:0] grant_o,
  output logic      [`DMG_NCH-1:0] pass_o,
  output logic      [`DMG_NCH-1:0] end_irq_o,
  output logic                     irq_o
);

  dmg_state_t st;
  dmg_state_t next_st;
  dmg_dec_t   dec [`DMG_NCH];
  logic       wr;

  // true for every address that holds a register
  function automatic logic addr_ok(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - `DMG_OFF_COUNT;
    if (a[1:0] != 2'b00)
      return 1'b0;
    if (a <= `DMG_OFF_STATE)
      return 1'b1;
    return (a >= `DMG_OFF_COUNT) && (rel[11:2] < 10'(`DMG_NCH));
  endfunction : addr_ok

  // count register index picked by an address
  function automatic int unsigned count_index(input logic [11:0] a);
    logic [11:0] rel;
    rel = a - `DMG_OFF_COUNT;
    return int'(rel[11:2]);
  endfunction : count_index

  // write strobe at the access edge that samples pready; shared with the checks below
  assign wr = apb_i.psel && apb_i.penable && apb_i.pwrite && st.rsp.pready && addr_ok(apb_i.paddr);

  generate
    for (genvar g = 0; g < `DMG_NCH; g++)
    begin : gen_gate
      dmg_gate u_gate (
        .grp_i                   (dmg_chan_group(g)),
        .nmi_i                   (nmi_i),
        .global_dma_enable_i     (st.global_dma_enable),
        .channel_enable_i        (st.channel_enable[g]),
        .count_zero_i            (st.transfer_count[g] == '0),
        .completion_valid_flag_i (st.completion_valid_flag[g]),
        .transfer_end_flag_i     (st.transfer_end_flag[g]),
        .dec_o                   (dec[g])
      );
    end
  endgenerate

  // next state: bus access, flags, request routing and grant
  always_comb
  begin
    logic                  setup;
    logic [`DMG_NCH-1:0]   clr_cvf;
    logic [`DMG_NCH-1:0]   clr_tef;
    logic [`DMG_NCH-1:0]   clr_rpf;
    logic [`DMG_IST_W-1:0] clr_ist;
    logic [`DMG_IST_W-1:0] ev;
    logic                  found;
    logic                  uses_end;
    logic                  cnt_wr;
    int unsigned           ci;
    next_st  = st;
    setup    = apb_i.psel && !apb_i.penable;
    clr_cvf  = '0;
    clr_tef  = '0;
    clr_rpf  = '0;
    clr_ist  = '0;
    ev       = '0;
    found    = 1'b0;
    uses_end = 1'b0;
    cnt_wr   = 1'b0;
    ci       = count_index(apb_i.paddr);

    // zero-wait answer: pready rises in the first access cycle
    next_st.rsp.pready = setup;
    if (setup)
    begin
      next_st.rsp.pslverr = !addr_ok(apb_i.paddr);
      next_st.rsp.prdata  = '0;
      case (apb_i.paddr)
        `DMG_OFF_CTRL:  next_st.rsp.prdata = {31'h0, st.global_dma_enable};
        `DMG_OFF_CHEN:  next_st.rsp.prdata = {22'h0, st.channel_enable};
        `DMG_OFF_IEN:   next_st.rsp.prdata = {22'h0, st.channel_interrupt_enable};
        `DMG_OFF_CVF:   next_st.rsp.prdata = {22'h0, st.completion_valid_flag};
        `DMG_OFF_TEF:   next_st.rsp.prdata = {22'h0, st.transfer_end_flag};
        `DMG_OFF_RPF:   next_st.rsp.prdata = {22'h0, st.reload_pointer_flag};
        `DMG_OFF_ISTAT: next_st.rsp.prdata = {29'h0, st.ist};
        `DMG_OFF_IMASK: next_st.rsp.prdata = {29'h0, st.imask};
        `DMG_OFF_STATE: next_st.rsp.prdata = {21'h0, nmi_i, st.pend};
        default:
          if (addr_ok(apb_i.paddr))
            next_st.rsp.prdata = {16'h0, st.transfer_count[ci]};
      endcase
    end
    else if (!apb_i.psel)
    begin
      next_st.rsp.pslverr = 1'b0;
    end

    // register writes take effect at the edge that samples pready
    if (wr)
    begin
      case (apb_i.paddr)
        `DMG_OFF_CTRL:  next_st.global_dma_enable        = apb_i.pwdata[0];
        `DMG_OFF_CHEN:  next_st.channel_enable           = apb_i.pwdata[`DMG_NCH-1:0];
        `DMG_OFF_IEN:   next_st.channel_interrupt_enable = apb_i.pwdata[`DMG_NCH-1:0];
        // zero clears completion and end flags
        `DMG_OFF_CVF:   clr_cvf = ~apb_i.pwdata[`DMG_NCH-1:0];
        `DMG_OFF_TEF:   clr_tef = ~apb_i.pwdata[`DMG_NCH-1:0];
        `DMG_OFF_RPF:   clr_rpf = apb_i.pwdata[`DMG_NCH-1:0];
        `DMG_OFF_ISTAT: clr_ist = apb_i.pwdata[`DMG_IST_W-1:0];
        `DMG_OFF_IMASK: next_st.imask = apb_i.pwdata[`DMG_IST_W-1:0];
        `DMG_OFF_STATE: next_st.imask = st.imask; // read-only
        default:        cnt_wr = 1'b1;
      endcase
    end

    // per channel: count, flags, routing of the incoming request
    for (int ch = 0; ch < `DMG_NCH; ch++)
    begin
      uses_end = (dmg_chan_group(ch) == GRP_TG_ADC) || (dmg_chan_group(ch) == GRP_SERIAL)
                 || (dmg_chan_group(ch) == GRP_CAN_TX);
      if (cnt_wr && (ci == ch))
        next_st.transfer_count[ch] = apb_i.pwdata[`DMG_CW-1:0];
      else if (xfer_done_i[ch] && (st.transfer_count[ch] != '0))
        next_st.transfer_count[ch] = st.transfer_count[ch] - `DMG_CW'(1);
      // a set in the clearing cycle survives
      next_st.completion_valid_flag[ch] = (st.completion_valid_flag[ch] && !clr_cvf[ch])
                                          || (xfer_done_i[ch] && !uses_end);
      next_st.transfer_end_flag[ch] = (st.transfer_end_flag[ch] && !clr_tef[ch])
                                      || (xfer_done_i[ch] && uses_end && (st.transfer_count[ch] == `DMG_CW'(1)));
      next_st.reload_pointer_flag[ch] = (st.reload_pointer_flag[ch] && !clr_rpf[ch]) || reload_i[ch];
      // pass straight on, no interrupt-enable gating
      next_st.pass[ch] = periph_req_i[ch] && (dec[ch] == DEC_PASS);
      ev[`DMG_IST_DROP] = ev[`DMG_IST_DROP] || (periph_req_i[ch] && (dec[ch] == DEC_MASK));
      ev[`DMG_IST_END]  = ev[`DMG_IST_END] || xfer_done_i[ch];
      next_st.end_irq[ch] = (next_st.completion_valid_flag[ch] || next_st.transfer_end_flag[ch])
                            && next_st.channel_interrupt_enable[ch];
    end

    // lowest pending enabled channel wins the grant
    next_st.grant = '0;
    for (int ch = 0; ch < `DMG_NCH; ch++)
    begin
      if (!found && st.pend[ch] && (dec[ch] == DEC_XFER))
      begin
        next_st.grant[ch] = 1'b1;
        next_st.pend[ch]  = 1'b0;
        found             = 1'b1;
      end
      // a fresh request beats the grant clear; suspended ones wait
      if (periph_req_i[ch] && (dec[ch] == DEC_XFER))
        next_st.pend[ch] = 1'b1;
    end

    // sticky block status, write one to clear, set wins
    ev[`DMG_IST_NMI] = nmi_i;
    next_st.ist = (st.ist & ~clr_ist) | ev;
    next_st.irq = |(next_st.ist & next_st.imask);
  end

  // state register
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st                   <= '0;
      st.global_dma_enable <= `DMG_RST_CTRL;
      st.channel_enable    <= `DMG_RST_CHAN;
      st.imask             <= `DMG_RST_IMASK;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs come straight from the state register
  assign apb_o     = st.rsp;
  assign grant_o   = st.grant;
  assign pass_o    = st.pass;
  assign end_irq_o = st.end_irq;
  assign irq_o     = st.irq;

  // checks, on the design's own state
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  tg_adc_gate_a: assert property (
    (!nmi_i && st.global_dma_enable) |-> dec[0] == ((st.transfer_count[0] == '0) ? DEC_PASS : DEC_XFER))
    else $error("converter channel decision wrong");
  timer_gate_a: assert property (
    !nmi_i |-> dec[2] == ((st.global_dma_enable && st.channel_enable[2]) ? DEC_XFER : DEC_PASS))
    else $error("timer channel decision wrong");
  serial_nmi_a: assert property (
    (nmi_i || !st.global_dma_enable) |-> dec[4] == (nmi_i ? DEC_MASK : DEC_PASS))
    else $error("serial channel not masked or passed");
  serial_end_a: assert property (
    (!nmi_i && st.global_dma_enable && st.transfer_end_flag[4]) |-> dec[4] == DEC_MASK)
    else $error("serial end flag does not mask");
  can_rx_gate_a: assert property (
    (dec[6] == DEC_XFER) |-> (!nmi_i && st.global_dma_enable && st.channel_enable[6]))
    else $error("can receive enabled wrongly");
  can_tx_gate_a: assert property (
    (!nmi_i && st.global_dma_enable && st.channel_enable[8])
      |-> dec[8] == (st.transfer_end_flag[8] ? DEC_OFF : DEC_XFER))
    else $error("can transmit decision wrong");
  flag_zero_clear_a: assert property (
    (wr && apb_i.paddr == `DMG_OFF_TEF && !apb_i.pwdata[4] && !xfer_done_i[4]) |=> !st.transfer_end_flag[4])
    else $error("end flag not cleared by zero");
  reload_clear_a: assert property (
    (wr && apb_i.paddr == `DMG_OFF_RPF && apb_i.pwdata[1] && !reload_i[1]) |=> !st.reload_pointer_flag[1])
    else $error("reload flag not cleared by one");
  masked_drop_a: assert property (
    (periph_req_i[4] && dec[4] == DEC_MASK) |=> !pass_o[4] ##1 !grant_o[4])
    else $error("masked request leaked");
  pass_route_a: assert property (
    (periph_req_i[2] && dec[2] == DEC_PASS) |=> pass_o[2])
    else $error("passed request not forwarded");
  end_irq_a: assert property (
    (xfer_done_i[2] && st.channel_interrupt_enable[2] && !(wr && apb_i.paddr == `DMG_OFF_IEN)) |=> end_irq_o[2])
    else $error("end interrupt missing");
  priority_a: assert property (
    (st.pend[0] && st.pend[1] && dec[0] == DEC_XFER) |=> grant_o[0] && !grant_o[1])
    else $error("priority order broken");
  refresh_a: assert property (
    (wr && apb_i.paddr == `DMG_OFF_CTRL && !apb_i.pwdata[0]) |=> dec[6] == DEC_OFF)
    else $error("decision not refreshed");

  // second layer: gating, routing, grant and flag handling
  cvf_zero_clear_a: assert property (
    (wr && apb_i.paddr == `DMG_OFF_CVF && !apb_i.pwdata[2] && !xfer_done_i[2]) |=> !st.completion_valid_flag[2])
    else $error("completion flag not cleared by zero");
  reload_keep_a: assert property (
    (wr && apb_i.paddr == `DMG_OFF_RPF && !apb_i.pwdata[3] && st.reload_pointer_flag[3]) |=> st.reload_pointer_flag[3])
    else $error("reload flag cleared by zero");
  timer_nmi_a: assert property (
    nmi_i |-> dec[3] == DEC_MASK)
    else $error("timer channel not masked on nmi");
  serial_xfer_a: assert property (
    (!nmi_i && st.global_dma_enable && !st.transfer_end_flag[4] && st.transfer_count[4] != '0)
      |-> dec[4] == DEC_XFER)
    else $error("serial channel not enabled");
  can_rx_on_a: assert property (
    (!nmi_i && st.global_dma_enable && st.channel_enable[6]) |-> dec[6] == DEC_XFER)
    else $error("can receive not enabled");
  can_tx_end_a: assert property (
    st.transfer_end_flag[8] |-> dec[8] != DEC_XFER)
    else $error("can transmit runs with end flag set");
  grant_onehot_a: assert property (
    $onehot0(grant_o))
    else $error("more than one grant");
  route_excl_a: assert property (
    (pass_o & grant_o) == '0)
    else $error("request both passed and granted");
  end_irq_track_a: assert property (
    end_irq_o == ((st.completion_valid_flag | st.transfer_end_flag) & st.channel_interrupt_enable))
    else $error("end interrupt out of step with flags");
  grant_enabled_a: assert property (
    grant_o[6] |-> $past(dec[6]) == DEC_XFER)
    else $error("grant without enabled decision");
  pass_ien_a: assert property (
    (periph_req_i[2] && dec[2] == DEC_PASS && !st.channel_interrupt_enable[2]) |=> pass_o[2])
    else $error("pass gated by interrupt enable");

  cov_xfer_c:  cover property (periph_req_i[0] && dec[0] == DEC_XFER ##[1:4] grant_o[0]);
  cov_pass_c:  cover property (periph_req_i[4] ##1 pass_o[4]);
  cov_end_c:   cover property (xfer_done_i[8] ##1 st.transfer_end_flag[8]);
  cov_irq_c:   cover property ($rose(irq_o));
  cov_mask_c:  cover property (periph_req_i[4] && dec[4] == DEC_MASK);

endmodule : dmg_top
